// >>> cal_counter.sv
// calibration counter: counts hclk cycles across a chosen number of slow periods
// assumes slow_rise is already a synchronised one-cycle pulse on hclk
`timescale 1ns/1ps
module cal_counter
  import slow_clock_pkg::*;
(
  input wire logic    hclk,
  input wire logic    hresetn,
  cal_link_if.counter cal
);

  typedef enum logic [1:0] {CAL_IDLE, CAL_ARM, CAL_RUN} cal_state_t;

  cal_state_t           state_ff;
  logic [COUNT_W-1:0]   cycles_ff;
  logic [PERIODS_W-1:0] seen_ff;
  logic [PERIODS_W-1:0] target;
  logic                 last_edge;

  // ==========================================================
  // end point
  always_comb begin
    target = periods_of(cal.capture_period_select);
    if (cal.capture_end_extend) begin
      target = target + EXTEND_CYCLES; // [RQ12]
    end
    last_edge = cal.slow_rise && (seen_ff == target - 12'h001);
  end

  // ==========================================================
  // sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= CAL_IDLE;
    end else begin
      case (state_ff)
        CAL_IDLE: if (cal.measure_enable) state_ff <= CAL_ARM; // [RQ13]
        CAL_ARM: begin
          if (!cal.measure_enable) state_ff <= CAL_IDLE;
          else if (cal.slow_rise) state_ff <= CAL_RUN; // [RQ20]
        end
        CAL_RUN: begin
          if (!cal.measure_enable) state_ff <= CAL_IDLE; // [RQ13]
          else if (last_edge) state_ff <= CAL_ARM;
        end
        default: state_ff <= CAL_IDLE;
      endcase
    end
  end

  // ==========================================================
  // cycle and period counting; wraps at 14 bits, wrap reported
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cycles_ff <= '0;
      seen_ff   <= '0;
    end else if (state_ff == CAL_ARM && cal.measure_enable && cal.slow_rise) begin
      cycles_ff <= '0;
      seen_ff   <= '0;
    end else if (state_ff == CAL_RUN && cal.measure_enable && !last_edge) begin
      cycles_ff <= cycles_ff + 14'h0001; // [RQ10]
      if (cal.slow_rise) seen_ff <= seen_ff + 12'h001;
    end
  end

  assign cal.measured_cycle_count = cycles_ff;
  assign cal.measure_paused       = (state_ff != CAL_RUN); // [RQ15]
  assign cal.capture_done         = (state_ff == CAL_RUN) && cal.measure_enable && last_edge;
  assign cal.count_overflow       = (state_ff == CAL_RUN) && cal.measure_enable && !last_edge
                                    && (cycles_ff == 14'h3FFF); // [RQ11]

endmodule

// >>> cal_link_if.sv
// signals between the register side and the calibration counter
// assumes both ends share hclk
`timescale 1ns/1ps
interface cal_link_if;
  import slow_clock_pkg::*;
  logic               measure_enable;
  logic               capture_end_extend;
  logic [2:0]         capture_period_select;
  logic               slow_rise;
  logic [COUNT_W-1:0] measured_cycle_count;
  logic               measure_paused;
  logic               capture_done;
  logic               count_overflow;

  modport regs (
    output measure_enable, capture_end_extend, capture_period_select, slow_rise,
    input  measured_cycle_count, measure_paused, capture_done, count_overflow
  );
  modport counter (
    input  measure_enable, capture_end_extend, capture_period_select, slow_rise,
    output measured_cycle_count, measure_paused, capture_done, count_overflow
  );
endinterface

// >>> slow_clock_ctrl.sv
// slow clock configuration, fast crystal tuning, pll byte and calibration registers
// assumes an ahb-lite master on hclk and an asynchronous slow clock pin
//
// Contract
// [RQ1] bit 7 of slow config shows the synchronised slow clock pin level
// [RQ2] bit 3 set turns the internal slow oscillator filter off, resets to 0
// [RQ3] bit 2 selects external slow source when set, internal at reset
// [RQ4] bit 1 powers the internal slow oscillator, resets to 1
// [RQ5] bit 0 powers the external slow oscillator, resets to 0
// [RQ6] fast crystal load cap code in bits 6..4, resets to 011
// [RQ7] fast crystal bias code in bits 1..0, resets to 10
// [RQ8] bit 15 of count register flags capture done, write 1 clears
// [RQ9] bit 14 reads overflow tally nonzero, write 1 clears the tally
// [RQ10] bits 13..0 show system cycles counted over the chosen slow periods
// [RQ11] eight-bit read-only tally of calibration counter overflows
// [RQ12] control bit 6 extends the end point by two slow cycles
// [RQ13] counting only while control bit 5 enable is set, reset 0
// [RQ14] control bit 4 enables the capture done interrupt, reset 0
// [RQ15] control bit 3 reads 1 while paused, 0 while counting
// [RQ16] bits 2..0 pick 1,2,4,32,64,128,1024,2047 periods, reset 001
// [RQ17] pll byte: flash mode bit 7 reset 0, field 6..0 reset 1001010
// [RQ18] software waits half a slow period after changing the source
// [RQ19] interrupt request high while done flag and its enable are set
// [RQ20] slow clock is synchronised before its edges steer counting
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module slow_clock_ctrl
  import slow_clock_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        slow_clock,
  output logic             slow_rc_filter_off,
  output logic             slow_source_external,
  output logic             slow_rc_power_on,
  output logic             slow_crystal_power_on,
  output logic      [2:0]  fast_crystal_load_cap,
  output logic      [1:0]  fast_crystal_bias,
  output logic             flash_control_mode,
  output logic      [6:0]  pll_parameter_field,
  output logic             cal_irq
);

  cal_link_if cal ();

  // ==========================================================
  // state
  logic               slow_meta_ff;
  logic               slow_sync_ff;
  logic               slow_prev_ff;
  logic               filter_off_ff;
  logic               source_ext_ff;
  logic               rc_pon_ff;
  logic               xtal_pon_ff;
  logic [2:0]         load_cap_ff;
  logic [1:0]         bias_ff;
  logic               end_extend_ff;
  logic               measure_en_ff;
  logic               irq_en_ff;
  logic [2:0]         period_sel_ff;
  logic               flash_mode_ff;
  logic [6:0]         pll_field_ff;
  logic               done_flag_ff;
  logic [OVF_W-1:0]   ovf_tally_ff;
  logic               irq_ff;
  logic               wr_pend_ff;
  logic [7:0]         wr_idx_ff;
  logic [31:0]        rdata_ff;
  logic               addr_phase;
  logic [7:0]         addr_idx;
  logic [31:0]        nxt_rdata;
  logic               done_clear;
  logic               ovf_clear;

  // ==========================================================
  // slow clock synchroniser; the first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_meta_ff <= 1'b0;
      slow_sync_ff <= 1'b0;
      slow_prev_ff <= 1'b0;
    end else begin
      slow_meta_ff <= slow_clock; // [RQ20]
      slow_sync_ff <= slow_meta_ff;
      slow_prev_ff <= slow_sync_ff;
    end
  end

  assign cal.slow_rise = slow_sync_ff && !slow_prev_ff; // [RQ20]

  // ==========================================================
  // ahb-lite address phase
  assign addr_phase = hsel && htrans[1] && hready;
  assign addr_idx   = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];

  // only whole-word single transfers are expected; hsize is not checked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
    end else begin
      wr_pend_ff <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_idx_ff <= addr_idx;
      end
    end
  end

  // zero wait states and always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================================
  // read mux, captured in the address phase; unmapped reads give zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (addr_idx)
      IDX_SLOW_CLOCK_CONFIG: begin
        nxt_rdata[POS_SLOW_PIN_LEVEL]     = slow_sync_ff; // [RQ1]
        nxt_rdata[POS_SLOW_RC_FILTER_OFF] = filter_off_ff;
        nxt_rdata[POS_SLOW_SOURCE_EXT]    = source_ext_ff;
        nxt_rdata[POS_SLOW_RC_POWER_ON]   = rc_pon_ff;
        nxt_rdata[POS_SLOW_XTAL_POWER_ON] = xtal_pon_ff;
      end
      IDX_FAST_CRYSTAL_TUNE: begin
        nxt_rdata[POS_LOAD_CAP_LSB +: 3] = load_cap_ff;
        nxt_rdata[POS_BIAS_LSB +: 2]     = bias_ff;
      end
      IDX_CALIBRATION_COUNT: begin
        nxt_rdata[POS_CAPTURE_DONE]      = done_flag_ff; // [RQ8]
        nxt_rdata[POS_OVF_NONZERO_CLEAR] = (ovf_tally_ff != '0); // [RQ9]
        nxt_rdata[COUNT_W-1:0]           = cal.measured_cycle_count; // [RQ10]
      end
      IDX_CALIBRATION_OV_CNT: begin
        nxt_rdata[OVF_W-1:0] = ovf_tally_ff; // [RQ11]
      end
      IDX_CALIBRATION_CONTROL: begin
        nxt_rdata[POS_CAPTURE_END_EXTEND] = end_extend_ff;
        nxt_rdata[POS_MEASURE_ENABLE]     = measure_en_ff;
        nxt_rdata[POS_DONE_IRQ_ENABLE]    = irq_en_ff;
        nxt_rdata[POS_MEASURE_PAUSED]     = cal.measure_paused; // [RQ15]
        nxt_rdata[POS_PERIOD_SEL_LSB +: 3] = period_sel_ff;
      end
      IDX_PLL_PARAMETERS: begin
        nxt_rdata[POS_FLASH_MODE]         = flash_mode_ff;
        nxt_rdata[POS_PLL_FIELD_LSB +: 7] = pll_field_ff;
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // slow clock configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filter_off_ff <= RST_RC_FILTER_OFF;
      source_ext_ff <= RST_SOURCE_EXT;
      rc_pon_ff     <= RST_RC_POWER_ON;
      xtal_pon_ff   <= RST_XTAL_POWER_ON;
    end else if (wr_pend_ff && wr_idx_ff == IDX_SLOW_CLOCK_CONFIG) begin
      filter_off_ff <= hwdata[POS_SLOW_RC_FILTER_OFF]; // [RQ2]
      // the new source is only trustworthy half a slow period later
      source_ext_ff <= hwdata[POS_SLOW_SOURCE_EXT]; // [RQ3]
      rc_pon_ff     <= hwdata[POS_SLOW_RC_POWER_ON]; // [RQ4]
      xtal_pon_ff   <= hwdata[POS_SLOW_XTAL_POWER_ON]; // [RQ5]
    end
  end

  // ==========================================================
  // fast crystal tuning
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_cap_ff <= RST_LOAD_CAP;
      bias_ff     <= RST_BIAS;
    end else if (wr_pend_ff && wr_idx_ff == IDX_FAST_CRYSTAL_TUNE) begin
      load_cap_ff <= hwdata[POS_LOAD_CAP_LSB +: 3]; // [RQ6]
      bias_ff     <= hwdata[POS_BIAS_LSB +: 2]; // [RQ7]
    end
  end

  // ==========================================================
  // pll parameter byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_mode_ff <= RST_FLASH_MODE;
      pll_field_ff  <= RST_PLL_FIELD;
    end else if (wr_pend_ff && wr_idx_ff == IDX_PLL_PARAMETERS) begin
      flash_mode_ff <= hwdata[POS_FLASH_MODE]; // [RQ17]
      pll_field_ff  <= hwdata[POS_PLL_FIELD_LSB +: 7]; // [RQ17]
    end
  end

  // ==========================================================
  // calibration control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      end_extend_ff <= RST_END_EXTEND;
      measure_en_ff <= RST_MEASURE_EN;
      irq_en_ff     <= RST_IRQ_ENABLE;
      period_sel_ff <= RST_PERIOD_SEL;
    end else if (wr_pend_ff && wr_idx_ff == IDX_CALIBRATION_CONTROL) begin
      end_extend_ff <= hwdata[POS_CAPTURE_END_EXTEND]; // [RQ12]
      measure_en_ff <= hwdata[POS_MEASURE_ENABLE]; // [RQ13]
      irq_en_ff     <= hwdata[POS_DONE_IRQ_ENABLE]; // [RQ14]
      period_sel_ff <= hwdata[POS_PERIOD_SEL_LSB +: 3]; // [RQ16]
    end
  end

  assign cal.measure_enable        = measure_en_ff;
  assign cal.capture_end_extend    = end_extend_ff;
  assign cal.capture_period_select = period_sel_ff;

  // ==========================================================
  // done flag and overflow tally; a set in the clearing cycle wins
  assign done_clear = wr_pend_ff && wr_idx_ff == IDX_CALIBRATION_COUNT
                      && hwdata[POS_CAPTURE_DONE];
  assign ovf_clear  = wr_pend_ff && wr_idx_ff == IDX_CALIBRATION_COUNT
                      && hwdata[POS_OVF_NONZERO_CLEAR];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_flag_ff <= 1'b0;
    end else if (cal.capture_done) begin
      done_flag_ff <= 1'b1; // [RQ8]
    end else if (done_clear) begin
      done_flag_ff <= 1'b0; // [RQ8]
    end
  end

  // tally saturates rather than wrapping so a nonzero value never reads as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_tally_ff <= '0;
    end else if (ovf_clear) begin
      ovf_tally_ff <= cal.count_overflow ? 8'h01 : 8'h00; // [RQ9]
    end else if (cal.count_overflow && ovf_tally_ff != 8'hFF) begin
      ovf_tally_ff <= ovf_tally_ff + 8'h01; // [RQ11]
    end
  end

  // ==========================================================
  // interrupt request, one cycle behind flag and enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= done_flag_ff && irq_en_ff; // [RQ19]
    end
  end

  // ==========================================================
  // calibration counter
  cal_counter u_cal_counter (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cal     (cal.counter)
  );

  // ==========================================================
  // outputs
  assign hrdata                = rdata_ff;
  assign slow_rc_filter_off    = filter_off_ff;
  assign slow_source_external  = source_ext_ff;
  assign slow_rc_power_on      = rc_pon_ff;
  assign slow_crystal_power_on = xtal_pon_ff;
  assign fast_crystal_load_cap = load_cap_ff;
  assign fast_crystal_bias     = bias_ff;
  assign flash_control_mode    = flash_mode_ff;
  assign pll_parameter_field   = pll_field_ff;
  assign cal_irq               = irq_ff;

endmodule

// >>> slow_clock_ctrl_sva.sv
// checker for slow_clock_ctrl: bus answer, register outputs, read data, irq
// assumes it is bound to slow_clock_ctrl and sees only that module's ports
`timescale 1ns/1ps
module slow_clock_ctrl_sva
  import slow_clock_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        slow_clock,
  input wire logic        slow_rc_filter_off,
  input wire logic        slow_source_external,
  input wire logic        slow_rc_power_on,
  input wire logic        slow_crystal_power_on,
  input wire logic [2:0]  fast_crystal_load_cap,
  input wire logic [1:0]  fast_crystal_bias,
  input wire logic        flash_control_mode,
  input wire logic [6:0]  pll_parameter_field,
  input wire logic        cal_irq
);
  // ==========================================================
  // data phase tracking, so each write or read is judged when it lands
  logic        acc_ff;
  logic        wr_ff;
  logic [7:0]  idx_ff;
  logic [31:0] wdat_ff;
  logic        wr_dp;
  logic        rd_dp;
  logic        mapped;
  logic [3:0]  cfg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= 1'b0;
      wr_ff <= 1'b0;
      idx_ff <= 8'h00;
      wdat_ff <= 32'h0000_0000;
    end else begin
      acc_ff <= hsel & htrans[1] & hready;
      wr_ff <= hwrite;
      idx_ff <= haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
      wdat_ff <= hwdata;
    end
  end
  assign wr_dp = acc_ff & wr_ff;
  assign rd_dp = acc_ff & ~wr_ff;
  assign mapped = idx_ff inside {IDX_SLOW_CLOCK_CONFIG, IDX_PLL_PARAMETERS, IDX_FAST_CRYSTAL_TUNE,
                                 IDX_CALIBRATION_COUNT, IDX_CALIBRATION_OV_CNT,
                                 IDX_CALIBRATION_CONTROL};
  assign cfg = {slow_rc_filter_off, slow_source_external, slow_rc_power_on, slow_crystal_power_on};

  // ==========================================================
  // properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  reset_vals_a: assert property (!$past(hresetn) |->
    cfg == 4'h2 && fast_crystal_load_cap == 3'h3 && fast_crystal_bias == 2'h2 &&
    {flash_control_mode, pll_parameter_field} == 8'h4A && !cal_irq)
    else $error("outputs not at reset values");
  cfg_write_a: assert property (wr_dp && idx_ff == IDX_SLOW_CLOCK_CONFIG |=>
    cfg == wdat_ff[3:0]) else $error("config write not applied");
  cfg_hold_a: assert property (!(wr_dp && idx_ff == IDX_SLOW_CLOCK_CONFIG) |=>
    $stable(cfg)) else $error("config outputs moved without a write");
  tune_write_a: assert property (wr_dp && idx_ff == IDX_FAST_CRYSTAL_TUNE |=>
    {fast_crystal_load_cap, fast_crystal_bias} == {wdat_ff[6:4], wdat_ff[1:0]})
    else $error("tune write not applied");
  pll_write_a: assert property (wr_dp && idx_ff == IDX_PLL_PARAMETERS |=>
    {flash_control_mode, pll_parameter_field} == wdat_ff[7:0]) else $error("pll write lost");
  rd_cfg_a: assert property (rd_dp && idx_ff == IDX_SLOW_CLOCK_CONFIG |->
    hrdata[6:0] == {3'h0, cfg} && hrdata[31:8] == 24'h0) else $error("config read wrong");
  rd_pll_a: assert property (rd_dp && idx_ff == IDX_PLL_PARAMETERS |->
    hrdata == {24'h0, flash_control_mode, pll_parameter_field}) else $error("pll read wrong");
  unmapped_zero_a: assert property (rd_dp && !mapped |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  irq_off_a: assert property (wr_dp && idx_ff == IDX_CALIBRATION_CONTROL &&
    !hwdata[POS_DONE_IRQ_ENABLE] |=> ##1 !cal_irq) else $error("irq high while disabled");
endmodule

bind slow_clock_ctrl slow_clock_ctrl_sva chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .slow_clock(slow_clock),
  .slow_rc_filter_off(slow_rc_filter_off), .slow_source_external(slow_source_external),
  .slow_rc_power_on(slow_rc_power_on), .slow_crystal_power_on(slow_crystal_power_on),
  .fast_crystal_load_cap(fast_crystal_load_cap), .fast_crystal_bias(fast_crystal_bias),
  .flash_control_mode(flash_control_mode), .pll_parameter_field(pll_parameter_field),
  .cal_irq(cal_irq));

// >>> slow_clock_ctrl_test.sv
// self-checking bench for slow_clock_ctrl over ahb-lite
// assumes the checker file is compiled with it; bench drives slow_clock
`timescale 1ns/1ps
module slow_clock_ctrl_test;
  import slow_clock_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        slow_clock = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        filt, src, rcpon, xpon, flash, cal_irq;
  logic [2:0]  load;
  logic [1:0]  bias;
  logic [6:0]  pll;
  logic [31:0] outs;
  logic [31:0] rv;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  logic [7:0]  ctl [3] = '{8'h30, 8'h31, 8'h70};
  int          nrise [3] = '{2, 3, 4};

  always #20 hclk = ~hclk;
  assign outs = {14'h0, cal_irq, flash, pll, load, bias, filt, src, rcpon, xpon};

  slow_clock_ctrl dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .slow_clock(slow_clock),
    .slow_rc_filter_off(filt), .slow_source_external(src), .slow_rc_power_on(rcpon),
    .slow_crystal_power_on(xpon), .fast_crystal_load_cap(load), .fast_crystal_bias(bias),
    .flash_control_mode(flash), .pll_parameter_field(pll), .cal_irq(cal_irq));

  // ==========================================================
  // bus and compare tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic near(input logic [31:0] seen, input int exp);
    // one cycle of slack: sync phase decides whether the closing edge counts
    check(seen, (seen >= exp - 1 && seen <= exp + 1) ? seen : 32'(exp));
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 64) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 64) n_mismatch++;
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
                    input logic [31:0] msk = 32'hFFFF_FFFF);
    bus(1'b0, idx, 32'h0000_0000);
    check(rv & msk, exp);
  endtask

  // slow clock rises n times inside a burst and rests low afterwards
  task automatic rises(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge hclk);
      slow_clock <= 1'b1;
      repeat (half) @(posedge hclk);
      slow_clock <= 1'b0;
    end
    repeat (8) @(posedge hclk);
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(outs, 32'h0000_94E2);
    rd(IDX_SLOW_CLOCK_CONFIG, 32'h0000_0002);
    rd(IDX_FAST_CRYSTAL_TUNE, 32'h0000_0032);
    rd(IDX_CALIBRATION_CONTROL, 32'h0000_0009);
    rd(IDX_CALIBRATION_COUNT, 32'h0000_0000, 32'h0000_C000);
    rd(IDX_PLL_PARAMETERS, 32'h0000_004A);
    rd(8'h00, 32'h0000_0000);
    $display("test reset values done");
    wr(IDX_SLOW_CLOCK_CONFIG, 32'hFFFF_FFFF);
    wr(IDX_FAST_CRYSTAL_TUNE, 32'hFFFF_FFFF);
    wr(IDX_PLL_PARAMETERS, 32'h0000_00B5);
    wr(8'h01, 32'hFFFF_FFFF);
    rd(8'h01, 32'h0000_0000);
    check(outs, 32'h0001_6BFF);
    rd(IDX_FAST_CRYSTAL_TUNE, 32'h0000_0073);
    rd(IDX_PLL_PARAMETERS, 32'h0000_00B5);
    slow_clock <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(IDX_SLOW_CLOCK_CONFIG, 32'h0000_008F);
    slow_clock <= 1'b0;
    repeat (4) @(posedge hclk);
    rd(IDX_SLOW_CLOCK_CONFIG, 32'h0000_000F);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_FAST_CRYSTAL_TUNE, 32'(i * 17));
      rd(IDX_FAST_CRYSTAL_TUNE, 32'(i * 17));
    end
    for (int i = 0; i < 8; i++) begin
      wr(IDX_CALIBRATION_CONTROL, 32'(i));
      rd(IDX_CALIBRATION_CONTROL, 32'(i + 8));
    end
    $display("test register access done");
    wr(IDX_CALIBRATION_CONTROL, 32'h0000_0010);
    rises(3, 8);
    rd(IDX_CALIBRATION_COUNT, 32'h0000_0000, 32'h0000_8000);
    check({31'h0, cal_irq}, 32'h0000_0000);
    $display("test disabled counter done");
    for (int k = 0; k < 3; k++) begin
      wr(IDX_CALIBRATION_CONTROL, {24'h0, ctl[k]});
      rises(nrise[k], 8);
      check({31'h0, cal_irq}, 32'h0000_0001);
      rd(IDX_CALIBRATION_COUNT, 32'h0000_8000, 32'h0000_C000);
      near({18'h0, rv[13:0]}, nrise[k] * 16 - 16);
      wr(IDX_CALIBRATION_CONTROL, 32'h0000_0000);
      rd(IDX_CALIBRATION_CONTROL, 32'h0000_0008);
      check({31'h0, cal_irq}, 32'h0000_0000);
      rd(IDX_CALIBRATION_COUNT, 32'h0000_8000, 32'h0000_8000);
      wr(IDX_CALIBRATION_COUNT, 32'h0000_8000);
      rd(IDX_CALIBRATION_COUNT, 32'h0000_0000, 32'h0000_8000);
    end
    $display("test measurement done");
    wr(IDX_CALIBRATION_CONTROL, 32'h0000_0036);
    rises(1025, 10);
    rd(IDX_CALIBRATION_COUNT, 32'h0000_C000, 32'h0000_C000);
    near({18'h0, rv[13:0]}, 4096);
    rd(IDX_CALIBRATION_OV_CNT, 32'h0000_0001);
    wr(IDX_CALIBRATION_CONTROL, 32'h0000_0000);
    wr(IDX_CALIBRATION_COUNT, 32'h0000_4000);
    rd(IDX_CALIBRATION_OV_CNT, 32'h0000_0000);
    rd(IDX_CALIBRATION_COUNT, 32'h0000_8000, 32'h0000_C000);
    $display("test overflow done");
    wrap_up();
  end

  // about 21k cycles expected; cut off well beyond that
  initial begin
    #1_600_000;
    n_mismatch++;
    wrap_up();
  end
endmodule

// >>> slow_clock_pkg.sv
// constants for the slow clock configuration and calibration block
// assumes a single word-wide ahb-lite slave with one register per word
package slow_clock_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_SLOW_CLOCK_CONFIG   = 8'h2F;
  localparam logic [7:0] IDX_PLL_PARAMETERS      = 8'h4B;
  localparam logic [7:0] IDX_FAST_CRYSTAL_TUNE   = 8'h4E;
  localparam logic [7:0] IDX_CALIBRATION_COUNT   = 8'h50;
  localparam logic [7:0] IDX_CALIBRATION_OV_CNT  = 8'h52;
  localparam logic [7:0] IDX_CALIBRATION_CONTROL = 8'h53;
  localparam int         ADDR_IDX_LSB            = 2;
  localparam int         ADDR_IDX_MSB            = 9;

  // ==========================================================
  // field positions
  localparam int POS_SLOW_PIN_LEVEL      = 7;
  localparam int POS_SLOW_RC_FILTER_OFF  = 3;
  localparam int POS_SLOW_SOURCE_EXT     = 2;
  localparam int POS_SLOW_RC_POWER_ON    = 1;
  localparam int POS_SLOW_XTAL_POWER_ON  = 0;
  localparam int POS_LOAD_CAP_LSB        = 4;
  localparam int POS_BIAS_LSB            = 0;
  localparam int POS_CAPTURE_DONE        = 15;
  localparam int POS_OVF_NONZERO_CLEAR   = 14;
  localparam int POS_CAPTURE_END_EXTEND  = 6;
  localparam int POS_MEASURE_ENABLE      = 5;
  localparam int POS_DONE_IRQ_ENABLE     = 4;
  localparam int POS_MEASURE_PAUSED      = 3;
  localparam int POS_PERIOD_SEL_LSB      = 0;
  localparam int POS_FLASH_MODE          = 7;
  localparam int POS_PLL_FIELD_LSB       = 0;

  // ==========================================================
  // values after reset
  localparam logic       RST_RC_FILTER_OFF = 1'b0;
  localparam logic       RST_SOURCE_EXT    = 1'b0;
  localparam logic       RST_RC_POWER_ON   = 1'b1;
  localparam logic       RST_XTAL_POWER_ON = 1'b0;
  localparam logic [2:0] RST_LOAD_CAP      = 3'h3;
  localparam logic [1:0] RST_BIAS          = 2'h2;
  localparam logic       RST_END_EXTEND    = 1'b0;
  localparam logic       RST_MEASURE_EN    = 1'b0;
  localparam logic       RST_IRQ_ENABLE    = 1'b0;
  localparam logic [2:0] RST_PERIOD_SEL    = 3'h1;
  localparam logic       RST_FLASH_MODE    = 1'b0;
  localparam logic [6:0] RST_PLL_FIELD     = 7'h4A;

  // ==========================================================
  // calibration counts
  localparam int          COUNT_W       = 14;
  localparam int          OVF_W         = 8;
  localparam int          PERIODS_W     = 12;
  localparam logic [11:0] EXTEND_CYCLES = 12'h002;

  // number of slow periods measured for each selector code
  function automatic logic [11:0] periods_of(input logic [2:0] sel);
    logic [11:0] p;
    p = 12'h001;
    case (sel)
      3'h0:    p = 12'h001;
      3'h1:    p = 12'h002;
      3'h2:    p = 12'h004;
      3'h3:    p = 12'h020;
      3'h4:    p = 12'h040;
      3'h5:    p = 12'h080;
      3'h6:    p = 12'h400;
      default: p = 12'h7FF;
    endcase
    return p;
  endfunction

endpackage
